// *** hdl/svm_pkg.sv ***
// constants, field layouts and carrier types of the supply-voltage monitor
// assumes a 10 MHz system clock and an AXI4-Lite register bus
package svm_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // bus geometry
  localparam int unsigned AXI_AW = 8;
  localparam int unsigned AXI_DW = 32;

  // register byte offsets
  localparam logic [AXI_AW-1:0] OFS_CONTROL  = 8'h00;
  localparam logic [AXI_AW-1:0] OFS_STATUS   = 8'h04;
  localparam logic [AXI_AW-1:0] OFS_MASK     = 8'h08;
  localparam logic [AXI_AW-1:0] OFS_VECTOR   = 8'h0C;
  localparam logic [AXI_AW-1:0] OFS_SET      = 8'h10;

  // decoded register selects
  typedef enum logic [2:0] {
    SVM_SEL_CONTROL = 3'h0,
    SVM_SEL_STATUS  = 3'h1,
    SVM_SEL_MASK    = 3'h2,
    SVM_SEL_VECTOR  = 3'h3,
    SVM_SEL_SET     = 3'h4,
    SVM_SEL_NONE    = 3'h7
  } svm_sel_t;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  //////////////////////////////////////////////////////////////////////////////
  // control register layout
  localparam int unsigned BIT_DETECT  = 5;
  localparam int unsigned BIT_ENABLE  = 4;
  localparam int unsigned BIT_BGBUF   = 3;
  localparam int unsigned LEVEL_MSB   = 2;
  localparam logic [7:0]  CONTROL_RST = 8'h00;
  localparam logic [7:0]  CONTROL_WMASK = 8'h1F;

  // status, mask and set registers: bit 0 is the supply-low request
  localparam int unsigned BIT_REQ     = 0;
  // vector register: bit 0 global enable, bit 1 multifunction enable
  localparam int unsigned BIT_GLOBAL  = 0;
  localparam int unsigned BIT_MULTI   = 1;

  typedef struct packed {
    logic [1:0] unused;
    logic       supply_low_detect_flag;
    logic       detector_enable;
    logic       bandgap_buffer_enable;
    logic [2:0] trip_level_select;
  } svm_control_t;

  // signals toward the analog comparator and bandgap
  typedef struct packed {
    logic       detector_on;
    logic       bandgap_on;
    logic [2:0] trip_level_select;
  } svm_analog_t;

  //////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned CLK_PERIOD_NS          = 100;
  localparam int unsigned DETECT_TO_IRQ_DELAY_NS = 20000;
  localparam logic [15:0] DETECT_TO_IRQ_CYCLES   =
    16'((DETECT_TO_IRQ_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

endpackage

// *** hdl/svm_sync.sv ***
// three-stage synchroniser with agreement filter
// assumes an asynchronous level input and one system clock
`timescale 1ns/10ps
module svm_sync
  import svm_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // level in and out
  input  wire logic async_in,
  output logic      sync_out
);

  logic stage1;
  logic stage2;
  logic stage3;

  // shift chain; stage1 feeds only stage2
  always_ff @(posedge clk) begin
    if (rst) begin
      stage1 <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // output moves once the last two stages agree
  always_ff @(posedge clk) begin
    if (rst) begin
      sync_out <= 1'b0;
    end else if (stage2 == stage3) begin
      sync_out <= stage3;
    end
  end

endmodule // svm_sync

// *** hdl/svm_monitor.sv ***
// supply-voltage monitor: control register, detect flag, delayed request,
// wake-up pulse and gated interrupt behind an AXI4-Lite slave
// assumes the comparator output is asynchronous and the strap is synchronous
//
// The AXI4-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
module svm_monitor
  import svm_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // axi4-lite write address
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  // axi4-lite write data
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [AXI_DW-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  // axi4-lite write response
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic [1:0]             s_axi_bresp,
  // axi4-lite read address
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [AXI_AW-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  // axi4-lite read data
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [AXI_DW-1:0]      s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  // analog side
  input  wire logic              supply_below_level,
  input  wire logic              reset_level_detector,
  output svm_analog_t            analog_ctrl,
  // power mode and system
  input  wire logic              low_power_mode,
  output logic                   wake_request,
  output logic                   irq
);

  //////////////////////////////////////////////////////////////////////////////
  // address decode, shared by read and write paths
  function automatic svm_sel_t svm_decode(input logic [AXI_AW-1:0] addr);
    unique case (addr)
      OFS_CONTROL: svm_decode = SVM_SEL_CONTROL;
      OFS_STATUS:  svm_decode = SVM_SEL_STATUS;
      OFS_MASK:    svm_decode = SVM_SEL_MASK;
      OFS_VECTOR:  svm_decode = SVM_SEL_VECTOR;
      OFS_SET:     svm_decode = SVM_SEL_SET;
      default:     svm_decode = SVM_SEL_NONE;
    endcase
  endfunction

  svm_control_t      control;
  logic              supply_low_irq_request;
  logic              supply_low_irq_enable;
  logic              global_irq_enable;
  logic              multifunction_enable;
  logic              below_sync;
  logic [15:0]       delay_count;
  logic              request_prev;
  logic              aw_held;
  logic              w_held;
  logic [AXI_AW-1:0] aw_addr;
  logic [AXI_DW-1:0] w_data;
  logic [3:0]        w_strb;
  logic              do_write;
  svm_sel_t          wsel;
  logic              wr_lane0;
  logic              delay_done;
  logic              clear_req;
  logic              set_req;

  //////////////////////////////////////////////////////////////////////////////
  // comparator input crosses into the clock domain
  svm_sync u_below_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in (supply_below_level),
    .sync_out (below_sync)
  );

  //////////////////////////////////////////////////////////////////////////////
  // write channel capture, either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;
  assign wsel          = svm_decode(aw_addr);
  assign wr_lane0      = do_write && w_strb[0];

  always_ff @(posedge clk) begin
    if (rst) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  // write response, error on unmapped address
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wsel == SVM_SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // control register: one process owns the whole struct, so the flag and
  // the software fields never have two drivers; top bits never stored
  always_ff @(posedge clk) begin
    if (rst) begin
      control.unused                 <= 2'h0;
      control.supply_low_detect_flag <= CONTROL_RST[BIT_DETECT];
      control.detector_enable        <= CONTROL_RST[BIT_ENABLE];
      control.bandgap_buffer_enable  <= CONTROL_RST[BIT_BGBUF];
      control.trip_level_select      <= CONTROL_RST[LEVEL_MSB:0];
    end else begin
      // flag tracks the comparator every cycle while the detector is enabled, in any power mode
      control.supply_low_detect_flag <= control.detector_enable
                                     && below_sync;
      if (wr_lane0 && wsel == SVM_SEL_CONTROL) begin
        control.unused                <= 2'h0;
        control.detector_enable       <= w_data[BIT_ENABLE];
        control.bandgap_buffer_enable <= w_data[BIT_BGBUF];
        control.trip_level_select     <= w_data[LEVEL_MSB:0];
      end
    end
  end

  // interrupt enables
  always_ff @(posedge clk) begin
    if (rst) begin
      supply_low_irq_enable <= 1'b0;
      global_irq_enable     <= 1'b0;
      multifunction_enable  <= 1'b0;
    end else if (wr_lane0) begin
      if (wsel == SVM_SEL_MASK) begin
        supply_low_irq_enable <= w_data[BIT_REQ];
      end
      if (wsel == SVM_SEL_VECTOR) begin
        global_irq_enable    <= w_data[BIT_GLOBAL];
        multifunction_enable <= w_data[BIT_MULTI];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // analog controls
  always_ff @(posedge clk) begin
    if (rst) begin
      analog_ctrl <= '0;
    end else begin
      analog_ctrl.detector_on       <= control.detector_enable;
      analog_ctrl.trip_level_select <= control.trip_level_select;
      analog_ctrl.bandgap_on        <= control.detector_enable
                                    || reset_level_detector
                                    || control.bandgap_buffer_enable;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // delay counter, restarts when the flag drops
  assign delay_done = (delay_count == DETECT_TO_IRQ_CYCLES - 16'h0001)
                   && control.supply_low_detect_flag;

  always_ff @(posedge clk) begin
    if (rst) begin
      delay_count <= 16'h0000;
    end else if (!control.supply_low_detect_flag) begin
      delay_count <= 16'h0000;
    end else if (delay_count != DETECT_TO_IRQ_CYCLES) begin
      delay_count <= delay_count + 16'h0001;
    end
  end

  // sticky request: hardware set beats software clear
  assign clear_req = wr_lane0 && wsel == SVM_SEL_STATUS && w_data[BIT_REQ];
  assign set_req   = wr_lane0 && wsel == SVM_SEL_SET && w_data[BIT_REQ];

  always_ff @(posedge clk) begin
    if (rst) begin
      supply_low_irq_request <= 1'b0;
    end else if (delay_done || set_req) begin
      supply_low_irq_request <= 1'b1;
    end else if (clear_req) begin
      supply_low_irq_request <= 1'b0;
    end
  end

  // wake pulse on the request's rising edge in low-power mode, enables ignored
  always_ff @(posedge clk) begin
    if (rst) begin
      request_prev <= 1'b0;
      wake_request <= 1'b0;
    end else begin
      request_prev <= supply_low_irq_request;
      wake_request <= supply_low_irq_request && !request_prev
                   && low_power_mode;
    end
  end

  // interrupt level gated by all three enables
  assign irq = supply_low_irq_request && supply_low_irq_enable
            && global_irq_enable && multifunction_enable;

  //////////////////////////////////////////////////////////////////////////////
  // read channel, one cycle latency
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      s_axi_rdata  <= '0;
      unique case (svm_decode(s_axi_araddr))
        SVM_SEL_CONTROL: s_axi_rdata[7:0] <= {2'h0, control[5:0]};
        SVM_SEL_STATUS:  s_axi_rdata[BIT_REQ] <= supply_low_irq_request;
        SVM_SEL_MASK:    s_axi_rdata[BIT_REQ] <= supply_low_irq_enable;
        SVM_SEL_VECTOR:  s_axi_rdata[1:0] <= {multifunction_enable, global_irq_enable};
        SVM_SEL_SET:     s_axi_rdata <= '0;
        SVM_SEL_NONE:    s_axi_rresp <= RESP_SLVERR;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  property p_level_write;
    @(posedge clk) disable iff (rst)
      (wr_lane0 && wsel == SVM_SEL_CONTROL)
      |=> ##1 analog_ctrl.trip_level_select == $past(w_data[LEVEL_MSB:0], 2);
  endproperty
  a_level_write: assert property (p_level_write)
    else $error("trip level did not follow control write");

  property p_detect_read;
    @(posedge clk) disable iff (rst)
      (s_axi_arvalid && s_axi_arready && svm_decode(s_axi_araddr) == SVM_SEL_CONTROL)
      |=> s_axi_rdata[BIT_DETECT] == $past(control.supply_low_detect_flag);
  endproperty
  a_detect_read: assert property (p_detect_read)
    else $error("detect flag read mismatch");

  property p_detector_off;
    @(posedge clk) disable iff (rst)
      !control.detector_enable |=> !analog_ctrl.detector_on && !control.supply_low_detect_flag;
  endproperty
  a_detector_off: assert property (p_detector_off)
    else $error("detector active while disabled");

  property p_bandgap;
    @(posedge clk) disable iff (rst)
      (control.detector_enable || reset_level_detector || control.bandgap_buffer_enable)
      |=> analog_ctrl.bandgap_on;
  endproperty
  a_bandgap: assert property (p_bandgap)
    else $error("bandgap off while requested");

  property p_top_bits;
    @(posedge clk) disable iff (rst)
      s_axi_rvalid |-> s_axi_rdata[7:6] == 2'h0;
  endproperty
  a_top_bits: assert property (p_top_bits)
    else $error("unimplemented bits read nonzero");

  property p_detect_follow;
    @(posedge clk) disable iff (rst)
      (control.detector_enable && below_sync)[*2] |-> control.supply_low_detect_flag;
  endproperty
  a_detect_follow: assert property (p_detect_follow)
    else $error("detect flag low while supply low");

  property p_request_cause;
    @(posedge clk) disable iff (rst)
      ($rose(supply_low_irq_request) && !$past(set_req))
      |-> $past(delay_count) == DETECT_TO_IRQ_CYCLES - 16'h0001;
  endproperty
  a_request_cause: assert property (p_request_cause)
    else $error("request set before delay elapsed");

  property p_wake;
    @(posedge clk) disable iff (rst)
      ($rose(supply_low_irq_request) && low_power_mode) |=> wake_request;
  endproperty
  a_wake: assert property (p_wake)
    else $error("no wake pulse on request rise");

  property p_sticky;
    @(posedge clk) disable iff (rst)
      (supply_low_irq_request && !clear_req) |=> supply_low_irq_request;
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("request cleared without software");

  property p_irq_gate;
    @(posedge clk) disable iff (rst)
      irq |-> global_irq_enable && multifunction_enable && supply_low_irq_enable;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt without all enables");

  property p_restart;
    @(posedge clk) disable iff (rst)
      !control.supply_low_detect_flag |=> delay_count == 16'h0000;
  endproperty
  a_restart: assert property (p_restart)
    else $error("delay count not restarted");

endmodule // svm_monitor

// *** verification/svm_analog_model.sv ***
// behavioural comparator and bandgap on the analog side of the monitor
// assumes the bench sets the supply level in millivolts
`timescale 1ns/10ps
module svm_analog_model
  import svm_pkg::*;
(
  // control from the monitor
  input  wire svm_analog_t ctrl,
  // supply seen by the comparator
  input  var  int          supply_mv,
  // comparator result, high = supply below level
  output logic             below
);
  ////////////////////////////////////////////////////////////////////////////////
  // trip level in millivolts for each select code
  localparam int LEVEL_MV [8] = '{2000, 2200, 2400, 2700, 3000, 3300, 3600, 4000};

  // unpowered comparator pulls low; plain compare, no hysteresis
  always_comb begin
    below = ctrl.detector_on && ctrl.bandgap_on
            && (supply_mv < LEVEL_MV[ctrl.trip_level_select]);
  end
endmodule // svm_analog_model

// *** verification/test_supply_voltage_monitor.sv ***
// self-checking bench for the supply-voltage monitor over AXI4-Lite
// assumes the analog model stands in for comparator and bandgap
`timescale 1ns/10ps
module test_supply_voltage_monitor
  import svm_pkg::*;
;
  ////////////////////////////////////////////////////////////////////////////////
  // signals
  logic              clk, rst, rld, lpm, below, wake, irq;
  logic              awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready;
  logic [AXI_AW-1:0] awaddr, araddr;
  logic [AXI_DW-1:0] wdata, rdata;
  logic [1:0]        bresp, rresp;
  logic [3:0]        wstrb;
  svm_analog_t       actl;
  int                supply_mv, err_total, compares, wake_cnt, cyc, w0, n;
  localparam int LEVEL_MV [8] = '{2000, 2200, 2400, 2700, 3000, 3300, 3600, 4000};

  // design and analog partner
  svm_monitor svm_monitor_inst (
    .clk(clk), .rst(rst),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .supply_below_level(below), .reset_level_detector(rld),
    .analog_ctrl(actl), .low_power_mode(lpm), .wake_request(wake), .irq(irq));
  svm_analog_model svm_analog_model_inst (.ctrl(actl), .supply_mv(supply_mv), .below(below));

  // 100 ns clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // wake pulse counter and hang limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (wake === 1'b1) wake_cnt <= wake_cnt + 1;
    if (cyc == 6000) begin
      err_total++;
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // compare and bus tasks
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_done, w_done, aw_go, w_go;
    logic [1:0] r;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge clk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= d;
    bready <= 1'b1;
    do begin
      @(negedge clk);
      aw_go = awvalid && awready;
      w_go = wvalid && wready;
      @(posedge clk);
      if (aw_go) awvalid <= 1'b0;
      if (w_go) wvalid <= 1'b0;
      aw_done = aw_done | aw_go;
      w_done = w_done | w_go;
    end while (!(aw_done && w_done));
    do @(negedge clk); while (bvalid !== 1'b1);
    r = bresp;
    @(posedge clk);
    bready <= 1'b0;
    chk_word({30'h0, r}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(negedge clk); while (arready !== 1'b1);
    @(posedge clk);
    arvalid <= 1'b0;
    do @(negedge clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    @(posedge clk);
    rready <= 1'b0;
    chk_word(d, ed);
    chk_word({30'h0, r}, {30'h0, er});
  endtask

  task automatic gap(input int c);
    repeat (c) @(posedge clk);
  endtask

  task automatic irq_is(input logic e);
    @(negedge clk);
    chk_bit(irq, e);
    @(posedge clk);
  endtask

  task automatic wrap_up();
    $display("mismatches=%0d comparisons=%0d", err_total, compares);
    if (err_total == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {rst, rld, lpm} = 3'b100;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    supply_mv = 5000;
    {err_total, compares, wake_cnt, cyc} = {32'd0, 32'd0, 32'd0, 32'd0};
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    // reset values and unmapped place
    for (int i = 0; i < 4; i++) rd(8'(4 * i), 32'h0, RESP_OKAY);
    rd(8'h14, 32'h0, RESP_SLVERR);
    wr(8'h14, 32'h1, RESP_SLVERR);
    // byte lane 0 masked: write answered but nothing stored
    wstrb <= 4'hE;
    wr(OFS_CONTROL, 32'h1F, RESP_OKAY);
    wstrb <= 4'hF;
    rd(OFS_CONTROL, 32'h0, RESP_OKAY);
    // every trip level, both sides of it
    for (int i = 0; i < 8; i++) begin
      wr(OFS_CONTROL, 32'hFFFF_FFF0 | 32'(i), RESP_OKAY);
      supply_mv <= LEVEL_MV[i] - 50;
      gap(12);
      rd(OFS_CONTROL, 32'h30 | 32'(i), RESP_OKAY);
      chk_word(32'(actl), {27'h0, 2'b11, 3'(i)});
      supply_mv <= LEVEL_MV[i] + 50;
      gap(12);
      rd(OFS_CONTROL, 32'h10 | 32'(i), RESP_OKAY);
    end
    // detector off, bandgap from buffer bit or reset detector
    wr(OFS_CONTROL, 32'h08, RESP_OKAY);
    supply_mv <= 1500;
    gap(12);
    rd(OFS_CONTROL, 32'h08, RESP_OKAY);
    chk_word(32'(actl), 32'h08);
    wr(OFS_CONTROL, 32'h00, RESP_OKAY);
    rld <= 1'b1;
    supply_mv <= 5000;
    gap(3);
    chk_word(32'(actl), 32'h08);
    rld <= 1'b0;
    // delayed request in sleep, restarted by a short dip
    lpm <= 1'b1;
    wr(OFS_STATUS, 32'h1, RESP_OKAY);
    wr(OFS_MASK, 32'h1, RESP_OKAY);
    wr(OFS_VECTOR, 32'h3, RESP_OKAY);
    wr(OFS_CONTROL, 32'h10, RESP_OKAY);
    supply_mv <= 1500;
    gap(100);
    supply_mv <= 5000;
    gap(20);
    irq_is(1'b0);
    w0 = wake_cnt;
    n = 0;
    supply_mv <= 1500;
    while (irq !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    chk_bit(n >= 200 && n <= 215, 1'b1);
    gap(3);
    chk_word(32'(wake_cnt - w0), 32'h1);
    rd(OFS_CONTROL, 32'h30, RESP_OKAY);
    rd(OFS_STATUS, 32'h1, RESP_OKAY);
    // interrupt gating by each enable
    wr(OFS_MASK, 32'h0, RESP_OKAY);
    irq_is(1'b0);
    wr(OFS_MASK, 32'h1, RESP_OKAY);
    for (int v = 0; v < 4; v++) begin
      wr(OFS_VECTOR, 32'(v), RESP_OKAY);
      irq_is(v == 3);
    end
    wr(OFS_STATUS, 32'h1, RESP_OKAY);
    rd(OFS_STATUS, 32'h0, RESP_OKAY);
    supply_mv <= 5000;
    gap(12);
    // wake-up with every interrupt enable off
    wr(OFS_MASK, 32'h0, RESP_OKAY);
    wr(OFS_VECTOR, 32'h0, RESP_OKAY);
    w0 = wake_cnt;
    supply_mv <= 1500;
    gap(230);
    supply_mv <= 5000;
    chk_word(32'(wake_cnt - w0), 32'h1);
    irq_is(1'b0);
    // preset request blocks the wake-up
    wr(OFS_STATUS, 32'h1, RESP_OKAY);
    wr(OFS_SET, 32'h1, RESP_OKAY);
    rd(OFS_SET, 32'h0, RESP_OKAY);
    rd(OFS_STATUS, 32'h1, RESP_OKAY);
    w0 = wake_cnt;
    supply_mv <= 1500;
    gap(230);
    supply_mv <= 5000;
    chk_word(32'(wake_cnt - w0), 32'h0);
    wrap_up();
  end
endmodule // test_supply_voltage_monitor
